// ---- rtl/rotate_pkg.sv ----
package rotate_pkg;

	// Opcodes, odd member of each pair takes an indirect operand
	localparam logic [7:0] OPC_RLC_DIR = 8'h10;
	localparam logic [7:0] OPC_RLC_IND = 8'h11;
	localparam logic [7:0] OPC_RR_DIR = 8'he0;
	localparam logic [7:0] OPC_RR_IND = 8'he1;

	// Operand byte layout for the short working-register form
	localparam int WR_HI_POS = 4;
	localparam logic [3:0] WR_PREFIX = 4'he;

	// Bit positions inside the byte
	localparam int MSB_POS = 7;
	localparam int LSB_POS = 0;

	// Whole instruction length in core clocks
	localparam int INSTR_CYCLES = 6;

	// Values after reset
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic FLAG_RST = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DECODE,
		ST_POINTER,
		ST_FETCH,
		ST_EXECUTE,
		ST_WRITE
	} state_t;

	typedef struct packed {
		state_t state;
		logic left_sel;
		logic indirect;
		logic carry;
		logic [7:0] addr;
		logic [7:0] operand;
		logic [7:0] result;
		logic flag_c;
		logic flag_z;
		logic flag_v;
		logic flag_s;
	} unit_state_t;

endpackage

// ---- rtl/rotate_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// Carries one rotate request and its combinational answer
interface rotate_if;
	logic left_sel;
	logic [7:0] operand;
	logic carry_in;
	logic [7:0] result;
	logic c_out;
	logic z_out;
	logic v_out;
	logic s_out;

	modport ctrl (
		output left_sel,
		output operand,
		output carry_in,
		input result,
		input c_out,
		input z_out,
		input v_out,
		input s_out
	);

	modport core (
		input left_sel,
		input operand,
		input carry_in,
		output result,
		output c_out,
		output z_out,
		output v_out,
		output s_out
	);
endinterface

`default_nettype wire

// ---- rtl/rotate_core.sv ----
`timescale 1ns/10ps
`default_nettype none

// Pure rotate datapath, no state; the controller registers its answer
module rotate_core (
	rotate_if.core rif
);
	import rotate_pkg::*;

	// Either rotate, carry chosen by direction
	always_comb begin
		if (rif.left_sel) begin
			// Old carry enters bit 0, old bit 7 leaves to carry
			rif.result = {rif.operand[MSB_POS-1:LSB_POS], rif.carry_in};
			rif.c_out = rif.operand[MSB_POS];
		end else begin
			// Bit 0 wraps to bit 7 and is also copied out
			rif.result = {rif.operand[LSB_POS],
				rif.operand[MSB_POS:LSB_POS+1]};
			rif.c_out = rif.operand[LSB_POS];
		end
	end

	// Flags from the written-back byte; overflow also compares the old bit 7
	assign rif.z_out = (rif.result == 8'h00);
	assign rif.v_out = rif.result[MSB_POS] ^ rif.operand[MSB_POS];
	assign rif.s_out = rif.result[MSB_POS];

endmodule

`default_nettype wire

// ---- rtl/byte_rotate_unit.sv ----
// Operation
// - Right rotate: shift down, bit 0 to 7
// - Right rotate: carry takes old bit 0
// - Zero flag set when result byte zero
// - Overflow set when sign bit changed
// - Sign flag copies result bit 7
// - Operand high nibble E selects working register
`timescale 1ns/10ps
`default_nettype none

module byte_rotate_unit (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] dst_byte,
	input wire logic [3:0] wr_bank,
	input wire logic carry_flag,
	output logic busy,
	output logic rf_rd_en,
	output logic [7:0] rf_rd_addr,
	input wire logic [7:0] rf_rd_data,
	output logic rf_wr_en,
	output logic [7:0] rf_wr_addr,
	output logic [7:0] rf_wr_data,
	output logic flag_we,
	output logic flag_c,
	output logic flag_z,
	output logic flag_v,
	output logic flag_s,
	output logic done
);
	import rotate_pkg::*;

	unit_state_t st_r;
	unit_state_t st_nxt;
	rotate_if rif ();

	// Cleared state, one field a line so a new field is hard to miss
	localparam unit_state_t ST_RST = '{
		state: ST_IDLE,
		left_sel: 1'b0,
		indirect: 1'b0,
		carry: FLAG_RST,
		addr: BYTE_RST,
		operand: BYTE_RST,
		result: BYTE_RST,
		flag_c: FLAG_RST,
		flag_z: FLAG_RST,
		flag_v: FLAG_RST,
		flag_s: FLAG_RST
	};

	// Elaboration checks: decode and sequencer lean on these values
	if (MSB_POS != 7) begin : g_chk_msb
		$error("rotate datapath needs bit 7 as its top bit");
	end
	if (LSB_POS != 0) begin : g_chk_lsb
		$error("rotate datapath needs bit 0 as its bottom bit");
	end
	if (WR_HI_POS != 4) begin : g_chk_nibble
		$error("working register form splits the byte in nibbles");
	end
	// Pairs may differ in bit 0 only, which marks the indirect form
	if (OPC_RLC_DIR[0] || OPC_RR_DIR[0] ||
		(OPC_RLC_IND != (OPC_RLC_DIR | 8'h01)) ||
		(OPC_RR_IND != (OPC_RR_DIR | 8'h01))) begin : g_chk_opc
		$error("rotate opcode pairs must differ in bit 0 only");
	end
	// One state per core clock, so the state count is the length
	if (int'(ST_WRITE) + 1 != INSTR_CYCLES) begin : g_chk_len
		$error("sequencer length differs from instruction length");
	end

	// Recognised rotate opcodes; also used to refuse anything else
	function automatic logic is_rotate(input logic [7:0] opc);
		is_rotate = (opc == OPC_RLC_DIR) || (opc == OPC_RLC_IND) ||
			(opc == OPC_RR_DIR) || (opc == OPC_RR_IND);
	endfunction

	// Left rotate pair shares every bit but bit 0 with its direct form
	function automatic logic opc_is_left(input logic [7:0] opc);
		opc_is_left = (opc[7:1] == OPC_RLC_DIR[7:1]);
	endfunction

	// Bit 0 of every rotate opcode marks the indirect operand
	function automatic logic opc_is_indirect(input logic [7:0] opc);
		opc_is_indirect = opc[LSB_POS];
	endfunction

	// Short working-register form: prefix nibble in the upper half
	function automatic logic is_working_reg(input logic [7:0] b);
		is_working_reg = (b[7:WR_HI_POS] == WR_PREFIX);
	endfunction

	// Register address from the operand byte, short form widened
	function automatic logic [7:0] resolve_addr(input logic [7:0] b,
		input logic [3:0] bank);
		if (is_working_reg(b)) begin
			resolve_addr = {bank, b[WR_HI_POS-1:0]};
		end else begin
			resolve_addr = b;
		end
	endfunction

	rotate_core rotate_core_inst (
		.rif(rif.core)
	);

	// Datapath sees the latched direction, operand and carry only
	assign rif.left_sel = st_r.left_sel;
	assign rif.operand = st_r.operand;
	assign rif.carry_in = st_r.carry;

	// Sequencer: every instruction spends the same six cycles
	always_comb begin
		st_nxt = st_r;
		unique case (st_r.state)
			ST_IDLE: begin
				// Unknown opcodes are silently ignored
				if (start && is_rotate(opcode)) begin
					st_nxt.state = ST_DECODE;
					st_nxt.left_sel = opc_is_left(opcode);
					st_nxt.indirect = opc_is_indirect(opcode);
					st_nxt.carry = carry_flag;
					st_nxt.addr = resolve_addr(dst_byte, wr_bank);
				end
			end
			ST_DECODE: begin
				// Spacer: the address was resolved at accept
				st_nxt.state = ST_POINTER;
			end
			ST_POINTER: begin
				// Direct form idles here so timing matches indirect
				if (st_r.indirect) begin
					st_nxt.addr = rf_rd_data;
				end
				st_nxt.state = ST_FETCH;
			end
			ST_FETCH: begin
				// Operand byte arrives in the same cycle as the strobe
				st_nxt.operand = rf_rd_data;
				st_nxt.state = ST_EXECUTE;
			end
			ST_EXECUTE: begin
				// Result and all four flags are latched together
				st_nxt.result = rif.result;
				st_nxt.flag_c = rif.c_out;
				st_nxt.flag_z = rif.z_out;
				st_nxt.flag_v = rif.v_out;
				st_nxt.flag_s = rif.s_out;
				st_nxt.state = ST_WRITE;
			end
			ST_WRITE: begin
				// Strobes for this cycle are decoded from the state
				st_nxt.state = ST_IDLE;
			end
		endcase
	end

	// All unit state in one register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Strobes decoded from the state register only, so a change in the
	// datapath can never glitch a read or write enable
	always_comb begin
		rf_rd_en = 1'b0;
		rf_wr_en = 1'b0;
		flag_we = 1'b0;
		done = 1'b0;
		busy = 1'b1;
		unique case (st_r.state)
			ST_IDLE: begin
				busy = 1'b0;
			end
			ST_DECODE: begin
				// Address already resolved at accept; nothing to fetch
			end
			ST_POINTER: begin
				// Pointer read only for the indirect form
				rf_rd_en = st_r.indirect;
			end
			ST_FETCH: begin
				rf_rd_en = 1'b1;
			end
			ST_EXECUTE: begin
				// Datapath settles into the state register this cycle
			end
			ST_WRITE: begin
				// Write-back and flag update share the last cycle
				rf_wr_en = 1'b1;
				flag_we = 1'b1;
				done = 1'b1;
			end
		endcase
	end

	// Read and write share the resolved address; data from the flops
	assign rf_rd_addr = st_r.addr;
	assign rf_wr_addr = st_r.addr;
	assign rf_wr_data = st_r.result;

	// Flags held in flops; half-carry and decimal not driven here
	assign flag_c = st_r.flag_c;
	assign flag_z = st_r.flag_z;
	assign flag_v = st_r.flag_v;
	assign flag_s = st_r.flag_s;

endmodule

`default_nettype wire

// ---- testbench/rf_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Register file seen by the unit; read is combinational
module rf_model (
	input wire logic core_clk,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem [256];
	// Inverted data when not read, so stale bytes never match
	assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
	always @(posedge core_clk) begin
		if (wr_en) mem[wr_addr] <= wr_data;
	end
endmodule
`default_nettype wire

// ---- testbench/rotate_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module rotate_properties import rotate_pkg::*; (
	input wire logic core_clk, srst, start, carry_flag, busy, rf_rd_en,
	input wire logic [7:0] opcode, dst_byte, rf_rd_addr, rf_rd_data,
	input wire logic [3:0] wr_bank,
	input wire logic rf_wr_en, flag_we, flag_c, flag_z, flag_v, flag_s,
	input wire logic [7:0] rf_wr_addr, rf_wr_data,
	input wire logic done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Accepted direct right rotate
	sequence rr_take;
		start && !busy && opcode == OPC_RR_DIR;
	endsequence
	property rr_p;
		logic [7:0] d;
		(rr_take ##3 (1'b1, d = rf_rd_data)) |-> ##2
			(rf_wr_data == {d[0], d[7:1]} && flag_c == d[0] &&
			flag_v == (d[0] ^ d[7]));
	endproperty
	property wreg_p;
		logic [7:0] a;
		(start && !busy && opcode == OPC_RR_DIR && dst_byte[7:4] == WR_PREFIX,
			a = {wr_bank, dst_byte[3:0]}) |-> ##5 rf_wr_addr == a;
	endproperty
	// Accepted direct left rotate, carry captured at accept
	sequence rlc_take;
		start && !busy && opcode == OPC_RLC_DIR;
	endsequence
	property rlc_p;
		logic ci;
		logic [7:0] d;
		(rlc_take, ci = carry_flag) ##3 (1'b1, d = rf_rd_data) |-> ##2
			(rf_wr_data == {d[6:0], ci} && flag_c == d[7]);
	endproperty
	rlc_result_a: assert property (rlc_p)
		else $error("rotate left wrong");
	rr_result_a: assert property (rr_p) else $error("rotate right wrong");
	wreg_addr_a: assert property (wreg_p) else $error("bad wr address");
	six_cycles_a: assert property (rr_take |=> !done [*4] ##1 done)
		else $error("done not at cycle five");
	done_pulse_a: assert property (done |=> !done) else $error("done long");
	done_idle_a: assert property (done |=> !busy) else $error("busy stuck");
	write_with_done_a: assert property (done |-> rf_wr_en && flag_we)
		else $error("write not with done");
	zero_flag_a: assert property (flag_we |-> flag_z == (rf_wr_data == 8'h00))
		else $error("zero flag wrong");
	sign_flag_a: assert property (flag_we |-> flag_s == rf_wr_data[7])
		else $error("sign flag wrong");
endmodule
bind byte_rotate_unit rotate_properties rotate_properties_inst (
	.core_clk(core_clk),
	.srst(srst),
	.start(start),
	.carry_flag(carry_flag),
	.busy(busy),
	.rf_rd_en(rf_rd_en),
	.opcode(opcode),
	.dst_byte(dst_byte),
	.rf_rd_addr(rf_rd_addr),
	.rf_rd_data(rf_rd_data),
	.wr_bank(wr_bank),
	.rf_wr_en(rf_wr_en),
	.flag_we(flag_we),
	.flag_c(flag_c),
	.flag_z(flag_z),
	.flag_v(flag_v),
	.flag_s(flag_s),
	.rf_wr_addr(rf_wr_addr),
	.rf_wr_data(rf_wr_data),
	.done(done)
);
`default_nettype wire

// ---- testbench/byte_rotate_unit_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module byte_rotate_unit_bench;
	logic core_clk = 0, srst = 1, start = 0, carry_flag = 0;
	logic [7:0] opcode = 8'h00, dst_byte = 8'h00;
	logic [3:0] wr_bank = 4'h0;
	logic busy, rf_rd_en, rf_wr_en, flag_we, flag_c, flag_z, flag_v, flag_s;
	logic done;
	logic [7:0] rf_rd_addr, rf_rd_data, rf_wr_addr, rf_wr_data;
	int num_errors = 0, checks_done = 0;
	always #10 core_clk = ~core_clk;
	logic [7:0] flags_seen;
	// Flags packed as C, Z, V, S for one compare
	assign flags_seen = {4'h0, flag_c, flag_z, flag_v, flag_s};
	byte_rotate_unit byte_rotate_unit_inst (
		.core_clk(core_clk),
		.srst(srst),
		.start(start),
		.opcode(opcode),
		.dst_byte(dst_byte),
		.wr_bank(wr_bank),
		.carry_flag(carry_flag),
		.busy(busy),
		.rf_rd_en(rf_rd_en),
		.rf_rd_addr(rf_rd_addr),
		.rf_rd_data(rf_rd_data),
		.rf_wr_en(rf_wr_en),
		.rf_wr_addr(rf_wr_addr),
		.rf_wr_data(rf_wr_data),
		.flag_we(flag_we),
		.flag_c(flag_c),
		.flag_z(flag_z),
		.flag_v(flag_v),
		.flag_s(flag_s),
		.done(done)
	);
	rf_model rf_model_inst (.core_clk(core_clk), .rd_en(rf_rd_en),
		.rd_addr(rf_rd_addr), .rd_data(rf_rd_data), .wr_en(rf_wr_en),
		.wr_addr(rf_wr_addr), .wr_data(rf_wr_data));
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// One instruction; pointer byte used only by the odd opcodes
	task automatic op(logic [7:0] o, d, logic [3:0] b, logic ci,
		logic [7:0] p, v, er, logic [3:0] ef);
		logic [7:0] a;
		a = (d[7:4] == 4'he) ? {b, d[3:0]} : d;
		@(negedge core_clk);
		// Preload off the edge so the model's own write never races it
		if (o[0]) begin
			rf_model_inst.mem[a] = p;
			a = p;
		end
		rf_model_inst.mem[a] = v;
		{start, opcode, dst_byte, wr_bank, carry_flag} = {1'b1, o, d, b, ci};
		@(posedge core_clk);
		@(negedge core_clk);
		start = 0;
		chk("busy", 8'h01, {7'h0, busy});
		repeat (4) @(posedge core_clk);
		#1;
		chk("done", 8'h01, {7'h0, done});
		chk("result", er, rf_wr_data);
		chk("address", a, rf_wr_addr);
		chk("flags", {4'h0, ef}, flags_seen);
		@(posedge core_clk);
		#1;
		chk("stored", er, rf_model_inst.mem[a]);
	endtask
	// Reset in mid-instruction clears the sequencer and held flags
	task automatic reset_mid();
		@(negedge core_clk);
		{start, opcode, dst_byte, carry_flag} = {1'b1, 8'he0, 8'h41, 1'b0};
		@(posedge core_clk);
		@(negedge core_clk);
		{start, srst} = 2'b01;
		@(posedge core_clk);
		@(negedge core_clk);
		srst = 0;
		chk("reset busy", 8'h00, {7'h0, busy});
		chk("reset flags", 8'h00, flags_seen);
		chk("reset data", 8'h00, rf_wr_data);
	endtask
	// Unknown opcode must leave the unit idle
	task automatic refuse_unknown();
		@(negedge core_clk);
		{start, opcode} = {1'b1, 8'h12};
		@(negedge core_clk);
		start = 0;
		chk("refused", 8'h00, {7'h0, busy});
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Back to back at six-cycle spacing, all four opcodes
	initial begin
		repeat (4) @(posedge core_clk);
		@(negedge core_clk) srst = 0;
		op(8'he0, 8'he6, 4'h0, 0, 0, 8'h31, 8'h98, 4'b1011);
		op(8'h10, 8'h40, 4'h0, 0, 0, 8'h8f, 8'h1e, 4'b1010);
		op(8'he0, 8'h41, 4'h0, 1, 0, 8'h00, 8'h00, 4'b0100);
		op(8'he1, 8'he3, 4'h5, 0, 8'h80, 8'h02, 8'h01, 4'b0000);
		op(8'h11, 8'h22, 4'h0, 1, 8'h90, 8'h40, 8'h81, 4'b0011);
		reset_mid();
		refuse_unknown();
		end_of_test();
	end
endmodule
`default_nettype wire
